// *** hw/acr_pkg.sv ***
// acr_pkg: register map, field layout, reset values and carrier types
// for the channel calibration register bank.
// assumes a 32-bit apb slave with one 16-bit register per aligned word.
package acr_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] ACR_IDX_C0_GHI = 6'h0c;
  localparam logic [5:0] ACR_IDX_C0_GLO = 6'h0d;
  localparam logic [5:0] ACR_IDX_C1_CFG = 6'h0e;
  localparam logic [5:0] ACR_IDX_C1_OHI = 6'h0f;
  localparam logic [5:0] ACR_IDX_C1_OLO = 6'h10;
  localparam logic [5:0] ACR_IDX_C1_GHI = 6'h11;
  localparam logic [5:0] ACR_IDX_C1_GLO = 6'h12;
  localparam logic [5:0] ACR_IDX_C2_CFG = 6'h13;
  localparam logic [5:0] ACR_IDX_C2_OHI = 6'h14;

  localparam int ACR_ADDR_W = 12;
  localparam int ACR_IDX_LSB = 2;

  // writable bit masks; reserved bits read as zero
  localparam logic [15:0] ACR_LO_MASK     = 16'hff00;
  localparam logic [15:0] ACR_C1_CFG_MASK = 16'hffc3;
  localparam logic [15:0] ACR_C2_CFG_MASK = 16'hfff7;

  // reset values
  localparam logic [15:0] ACR_GHI_RST  = 16'h8000;
  localparam logic [15:0] ACR_ZERO_RST = 16'h0000;

  // field positions in the channel configuration words
  localparam int ACR_DELAY_LSB = 6;
  localparam int ACR_DELAY_MSB = 15;
  localparam int ACR_TEMP_SOURCE_SELECT_BIT = 5;
  localparam int ACR_TEMP_MEASURE_ON_BIT  = 4;
  localparam int ACR_TS_INV_BIT = 2;
  localparam int ACR_SEL_MSB    = 1;

  // sample delay: signed phase biased to an unsigned wait count
  localparam logic [10:0] ACR_DELAY_BIAS = 11'h200;

  // trim formats
  localparam int ACR_TRIM_W = 24;
  localparam logic [23:0] ACR_GAIN_UNITY = 24'h800000;
  localparam int ACR_GAIN_FRAC = 23;

  typedef enum logic [1:0] {
    ACR_SEL_PINS  = 2'b00,
    ACR_SEL_SHORT = 2'b01,
    ACR_SEL_DC    = 2'b10,
    ACR_SEL_AC    = 2'b11
  } acr_sel_t;

  typedef enum logic [0:0] {
    ACR_DLY_IDLE = 1'b0,
    ACR_DLY_WAIT = 1'b1
  } acr_dly_st_t;

  typedef struct packed {
    logic [9:0] sample_delay;
    acr_sel_t   input_select;
  } acr_chan_cfg_t;

  typedef struct packed {
    logic temp_source_select;
    logic temp_measure_on;
    logic temp_input_invert;
  } acr_temp_ctl_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } acr_conv_t;

endpackage : acr_pkg

// *** hw/acr_regs.sv ***
// acr_regs: channel configuration and calibration register bank on apb,
// with sample delay timers and trim of three conversion results.
// assumes mod_tick and sample_req are single-cycle strobes on pclk.
`timescale 1ns/1ps
// Notes on behaviour
// - gain trim is 24-bit unsigned, high word bits 23:8, low word byte 7:0.
// - low byte of every low trim word is reserved and reads zero.
// - gain high words reset to 8000h and gain low words to 0000h.
// - offset trim is 24-bit two's complement split like the gain trim.
// - config bits 15:6 hold a signed phase that shifts the sampling.
// - channel 1 input select picks pins, short, dc or ac diagnostics.
// - channel 2 input select uses the same four codes.
// - channel 2 bit 5 picks internal or external temperature sensor.
// - channel 2 bit 4 turns temperature measurement on, reset off.
// - channel 2 bit 2 inverts the temperature sensor inputs.
// - config, offset and gain low registers reset to 0000h.
// - channel 1 has five consecutive registers from 0Eh, channel 2 has two from 13h.
module acr_regs
  import acr_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ACR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  mod_tick,
  input  wire logic                  sample_req,
  output logic [1:0]                 chan_sample,
  output acr_chan_cfg_t              chan1_cfg,
  output acr_chan_cfg_t              chan2_cfg,
  output acr_temp_ctl_t              temp_ctl,
  input  wire acr_conv_t [2:0]       conv_raw,
  output acr_conv_t [2:0]            conv_trim
);

  // storage
  logic [15:0] c0_ghi_r;
  logic [15:0] c0_glo_r;
  logic [15:0] c1_cfg_r;
  logic [15:0] c1_ohi_r;
  logic [15:0] c1_olo_r;
  logic [15:0] c1_ghi_r;
  logic [15:0] c1_glo_r;
  logic [15:0] c2_cfg_r;
  logic [15:0] c2_ohi_r;
  logic [31:0] prdata_r;

  // address decode
  logic [5:0]  idx;
  logic        addr_ok;
  logic        hit_c0_ghi;
  logic        hit_c0_glo;
  logic        hit_c1_cfg;
  logic        hit_c1_ohi;
  logic        hit_c1_olo;
  logic        hit_c1_ghi;
  logic        hit_c1_glo;
  logic        hit_c2_cfg;
  logic        hit_c2_ohi;
  logic        hit_any;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic [15:0] lane_mask;
  logic [15:0] wdata16;
  logic [15:0] rd_word;

  assign idx     = paddr[ACR_IDX_LSB+5:ACR_IDX_LSB];
  assign addr_ok = (paddr[1:0] == 2'h0)
                && (paddr[ACR_ADDR_W-1:ACR_IDX_LSB+6] == '0);

  // two, five and two registers for channels 0, 1 and 2 in fixed order
  assign hit_c0_ghi = addr_ok && (idx == ACR_IDX_C0_GHI);
  assign hit_c0_glo = addr_ok && (idx == ACR_IDX_C0_GLO);
  assign hit_c1_cfg = addr_ok && (idx == ACR_IDX_C1_CFG);
  assign hit_c1_ohi = addr_ok && (idx == ACR_IDX_C1_OHI);
  assign hit_c1_olo = addr_ok && (idx == ACR_IDX_C1_OLO);
  assign hit_c1_ghi = addr_ok && (idx == ACR_IDX_C1_GHI);
  assign hit_c1_glo = addr_ok && (idx == ACR_IDX_C1_GLO);
  assign hit_c2_cfg = addr_ok && (idx == ACR_IDX_C2_CFG);
  assign hit_c2_ohi = addr_ok && (idx == ACR_IDX_C2_OHI);

  assign hit_any = hit_c0_ghi | hit_c0_glo | hit_c1_cfg | hit_c1_ohi
                 | hit_c1_olo | hit_c1_ghi | hit_c1_glo | hit_c2_cfg
                 | hit_c2_ohi;

  // apb handshake: zero wait states, error on unmapped address
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = access && !hit_any;
  assign wr_en   = access && pwrite && hit_any;

  // only byte lanes 0 and 1 carry register bits
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata16   = pwdata[15:0];

  // next values, masked by byte strobes and writable bits
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [15:0] lanes,
    input logic [15:0] wmask
  );
    logic [15:0] m;
    m = lanes & wmask;
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  logic [15:0] c0_ghi_nxt;
  logic [15:0] c0_glo_nxt;
  logic [15:0] c1_cfg_nxt;
  logic [15:0] c1_ohi_nxt;
  logic [15:0] c1_olo_nxt;
  logic [15:0] c1_ghi_nxt;
  logic [15:0] c1_glo_nxt;
  logic [15:0] c2_cfg_nxt;
  logic [15:0] c2_ohi_nxt;

  assign c0_ghi_nxt = merge(c0_ghi_r, wdata16, lane_mask, 16'hffff);
  // low trim words keep only the upper byte
  assign c0_glo_nxt = merge(c0_glo_r, wdata16, lane_mask, ACR_LO_MASK);
  // reserved config bits never store
  assign c1_cfg_nxt = merge(c1_cfg_r, wdata16, lane_mask, ACR_C1_CFG_MASK);
  assign c1_ohi_nxt = merge(c1_ohi_r, wdata16, lane_mask, 16'hffff);
  assign c1_olo_nxt = merge(c1_olo_r, wdata16, lane_mask, ACR_LO_MASK);
  assign c1_ghi_nxt = merge(c1_ghi_r, wdata16, lane_mask, 16'hffff);
  assign c1_glo_nxt = merge(c1_glo_r, wdata16, lane_mask, ACR_LO_MASK);
  assign c2_cfg_nxt = merge(c2_cfg_r, wdata16, lane_mask, ACR_C2_CFG_MASK);
  assign c2_ohi_nxt = merge(c2_ohi_r, wdata16, lane_mask, 16'hffff);

  // register file with documented resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_ghi_r <= ACR_GHI_RST;
      c0_glo_r <= ACR_ZERO_RST;
      c1_cfg_r <= ACR_ZERO_RST;
      c1_ohi_r <= ACR_ZERO_RST;
      c1_olo_r <= ACR_ZERO_RST;
      c1_ghi_r <= ACR_GHI_RST;
      c1_glo_r <= ACR_ZERO_RST;
      c2_cfg_r <= ACR_ZERO_RST;
      c2_ohi_r <= ACR_ZERO_RST;
    end else if (wr_en) begin
      if (hit_c0_ghi) c0_ghi_r <= c0_ghi_nxt;
      if (hit_c0_glo) c0_glo_r <= c0_glo_nxt;
      if (hit_c1_cfg) c1_cfg_r <= c1_cfg_nxt;
      if (hit_c1_ohi) c1_ohi_r <= c1_ohi_nxt;
      if (hit_c1_olo) c1_olo_r <= c1_olo_nxt;
      if (hit_c1_ghi) c1_ghi_r <= c1_ghi_nxt;
      if (hit_c1_glo) c1_glo_r <= c1_glo_nxt;
      if (hit_c2_cfg) c2_cfg_r <= c2_cfg_nxt;
      if (hit_c2_ohi) c2_ohi_r <= c2_ohi_nxt;
    end
  end

  // read mux; reserved bits already zero in storage
  assign rd_word = ({16{hit_c0_ghi}} & c0_ghi_r)
                 | ({16{hit_c0_glo}} & (c0_glo_r & ACR_LO_MASK))
                 | ({16{hit_c1_cfg}} & (c1_cfg_r & ACR_C1_CFG_MASK))
                 | ({16{hit_c1_ohi}} & c1_ohi_r)
                 | ({16{hit_c1_olo}} & (c1_olo_r & ACR_LO_MASK))
                 | ({16{hit_c1_ghi}} & c1_ghi_r)
                 | ({16{hit_c1_glo}} & (c1_glo_r & ACR_LO_MASK))
                 | ({16{hit_c2_cfg}} & (c2_cfg_r & ACR_C2_CFG_MASK))
                 | ({16{hit_c2_ohi}} & c2_ohi_r);

  // read data captured in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup) begin
      prdata_r <= (!pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;

  // channel configuration fields
  assign chan1_cfg.sample_delay = c1_cfg_r[ACR_DELAY_MSB:ACR_DELAY_LSB];
  assign chan1_cfg.input_select =
    acr_sel_t'(c1_cfg_r[ACR_SEL_MSB:0]);
  assign chan2_cfg.sample_delay = c2_cfg_r[ACR_DELAY_MSB:ACR_DELAY_LSB];
  assign chan2_cfg.input_select =
    acr_sel_t'(c2_cfg_r[ACR_SEL_MSB:0]);

  // temperature sensor controls
  assign temp_ctl.temp_source_select = c2_cfg_r[ACR_TEMP_SOURCE_SELECT_BIT];
  assign temp_ctl.temp_measure_on    = c2_cfg_r[ACR_TEMP_MEASURE_ON_BIT];
  assign temp_ctl.temp_input_invert  = c2_cfg_r[ACR_TS_INV_BIT];

  // sample delay timers, one per configurable channel
  logic [9:0]  phase [2];
  acr_dly_st_t dly_st_r [2];
  acr_dly_st_t dly_st_nxt [2];
  logic [10:0] dly_cnt_r [2];
  logic [10:0] dly_cnt_nxt [2];
  logic [1:0]  fire;
  logic [1:0]  chan_sample_r;

  assign phase[0] = chan1_cfg.sample_delay;
  assign phase[1] = chan2_cfg.sample_delay;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dly
      // signed phase biased so that -512 fires first and +511 last
      always_comb begin
        dly_st_nxt[g]  = dly_st_r[g];
        dly_cnt_nxt[g] = dly_cnt_r[g];
        fire[g]        = 1'b0;
        unique case (dly_st_r[g])
          ACR_DLY_IDLE: begin
            if (sample_req) begin
              dly_cnt_nxt[g] = {phase[g][9], phase[g]}
                             + ACR_DELAY_BIAS;
              dly_st_nxt[g]  = ACR_DLY_WAIT;
            end
          end
          ACR_DLY_WAIT: begin
            if (dly_cnt_r[g] == 11'h000) begin
              fire[g]       = 1'b1;
              dly_st_nxt[g] = ACR_DLY_IDLE;
            end else if (mod_tick) begin
              dly_cnt_nxt[g] = dly_cnt_r[g] - 11'h001;
            end
          end
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dly_st_r[g]      <= ACR_DLY_IDLE;
          dly_cnt_r[g]     <= '0;
          chan_sample_r[g] <= 1'b0;
        end else begin
          dly_st_r[g]      <= dly_st_nxt[g];
          dly_cnt_r[g]     <= dly_cnt_nxt[g];
          chan_sample_r[g] <= fire[g];
        end
      end
    end
  endgenerate

  assign chan_sample = chan_sample_r;

  // 24-bit trim words joined from high and low registers where both exist; channel 0 offset is zero, channel 2 gain unity
  logic [23:0] trim_off [3];
  logic [23:0] trim_gain [3];

  assign trim_off[0]  = 24'h000000;
  assign trim_gain[0] = {c0_ghi_r, c0_glo_r[15:8]};
  assign trim_off[1]  = {c1_ohi_r, c1_olo_r[15:8]};
  assign trim_gain[1] = {c1_ghi_r, c1_glo_r[15:8]};
  assign trim_off[2]  = {c2_ohi_r, 8'h00};
  assign trim_gain[2] = ACR_GAIN_UNITY;

  generate
    for (g = 0; g < 3; g++) begin : g_trim
      // offset subtract then gain multiply per channel
      acr_trim u_trim (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (conv_raw[g]),
        .offset  (trim_off[g]),
        .gain    (trim_gain[g]),
        .trimmed (conv_trim[g])
      );
    end
  endgenerate

endmodule : acr_regs

// *** hw/acr_trim.sv ***
// acr_trim: applies offset and gain trim to one channel's result.
// assumes raw results arrive as one-cycle valid strobes on pclk.
`timescale 1ns/1ps
module acr_trim
  import acr_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire acr_conv_t raw,
  input  wire logic [23:0] offset,
  input  wire logic [23:0] gain,
  output acr_conv_t      trimmed
);

  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [26:0] scaled;
  logic               ovf;
  logic [23:0]        sat_nxt;
  acr_conv_t          trimmed_r;

  // subtract offset, multiply by unsigned gain
  assign diff   = $signed({raw.data[23], raw.data})
                - $signed({offset[23], offset});
  assign prod   = diff * $signed({1'b0, gain});
  assign scaled = prod[49:ACR_GAIN_FRAC];
  assign ovf    = (scaled[26:23] != {4{scaled[23]}});
  assign sat_nxt = !ovf ? scaled[23:0] :
                   (scaled[26] ? 24'h800000 : 24'h7fffff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trimmed_r <= '0;
    end else begin
      trimmed_r.valid <= raw.valid;
      if (raw.valid) begin
        trimmed_r.data <= sat_nxt;
      end
    end
  end

  assign trimmed = trimmed_r;

endmodule : acr_trim

// *** test/acr_regs_properties.sv ***
// acr_regs_chk: port assertions for the calibration register bank.
// assumes binding to acr_regs with zero-wait apb.
`timescale 1ns/1ps
module acr_regs_chk
  import acr_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [3:0]      pstrb,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  input wire logic [1:0]      chan_sample,
  input wire acr_chan_cfg_t   chan1_cfg,
  input wire acr_temp_ctl_t   temp_ctl,
  input wire acr_conv_t [2:0] conv_raw,
  input wire acr_conv_t [2:0] conv_trim
);
  wire logic [5:0] idx = paddr[7:2];
  wire logic acc = psel && penable;
  wire logic hit = paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0 &&
                   idx >= ACR_IDX_C0_GHI && idx <= ACR_IDX_C2_OHI;
  wire logic lo = idx == ACR_IDX_C0_GLO || idx == ACR_IDX_C1_OLO ||
                  idx == ACR_IDX_C1_GLO;
  wire logic rd = acc && !pwrite && hit;
  wire logic wr = acc && pwrite && hit;
  wire logic [2:0] rv = {conv_raw[2].valid, conv_raw[1].valid,
                         conv_raw[0].valid};
  wire logic [2:0] tv = {conv_trim[2].valid, conv_trim[1].valid,
                         conv_trim[0].valid};
  logic [15:0] wd_r;
  always_ff @(posedge pclk) wd_r <= pwdata[15:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_map_decode: assert property (acc |-> pslverr == !hit)
    else $error("error flag wrong for address");
  a_low_reserved: assert property (rd && lo |-> prdata[7:0] == 8'h00)
    else $error("low trim byte not zero");
  a_cfg1_reserved: assert property (
    rd && idx == ACR_IDX_C1_CFG |-> prdata[5:2] == 4'h0)
    else $error("chan1 reserved bits not zero");
  a_cfg2_reserved: assert property (
    rd && idx == ACR_IDX_C2_CFG |-> !prdata[3])
    else $error("chan2 reserved bit not zero");
  a_cfg1_fields: assert property (
    wr && idx == ACR_IDX_C1_CFG && pstrb[1:0] == 2'b11
    |=> chan1_cfg == {wd_r[15:6], wd_r[1:0]})
    else $error("chan1 config outputs wrong");
  a_temp_fields: assert property (
    wr && idx == ACR_IDX_C2_CFG && pstrb[0]
    |=> temp_ctl == {wd_r[5], wd_r[4], wd_r[2]})
    else $error("temperature controls wrong");
  a_trim_strobe: assert property (1 |=> tv == $past(rv))
    else $error("trim valid not one cycle after raw");
  a_sample_pulse: assert property (chan_sample[0] |=> !chan_sample[0])
    else $error("sample strobe longer than one cycle");
  a_chan2_pulse: assert property (
    chan_sample[1] |=> !chan_sample[1])
    else $error("chan2 sample strobe longer than one cycle");
endmodule : acr_regs_chk
bind acr_regs acr_regs_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .chan_sample(chan_sample), .chan1_cfg(chan1_cfg), .temp_ctl(temp_ctl),
  .conv_raw(conv_raw), .conv_trim(conv_trim));

// *** test/acr_regs_test.sv ***
// acr_regs_test: self-checking bench for the calibration register bank.
// assumes zero-wait apb and a single pclk domain.
`timescale 1ns/1ps
module acr_regs_test
  import acr_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic mod_tick = 0, sample_req = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, rnd = 32'hafb92261;
  logic [3:0] pstrb = 0;
  logic [1:0] chan_sample;
  acr_chan_cfg_t c1, c2;
  acr_temp_ctl_t tc;
  acr_conv_t [2:0] raw = '0, trim;
  logic [15:0] mdl [12:20];
  int bad_count = 0, checked = 0, cyc = 0, k;
  always #50 pclk = ~pclk;
  acr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mod_tick(mod_tick), .sample_req(sample_req), .chan_sample(chan_sample),
    .chan1_cfg(c1), .chan2_cfg(c2), .temp_ctl(tc), .conv_raw(raw),
    .conv_trim(trim));
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs
  function automatic logic [15:0] wmask(int i);
    case (i)
      13, 16, 18: return 16'hff00;
      14: return 16'hffc3;
      19: return 16'hfff7;
      default: return 16'hffff;
    endcase
  endfunction : wmask
  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  task complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic apb(logic w, logic [11:0] a, logic [15:0] d,
                     logic [3:0] s, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(int i, logic [15:0] d, logic [3:0] s);
    logic [31:0] rd;
    logic er;
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & wmask(i);
    apb(1'b1, 12'(4 * i), d, s, rd, er);
    chk_val("write error", {31'h0, i < 12 || i > 20}, {31'h0, er});
    if (i >= 12 && i <= 20) mdl[i] = (mdl[i] & ~m) | (d & m);
  endtask : wr
  task automatic rdchk(int i);
    logic [31:0] rd;
    logic er;
    logic [31:0] ex;
    ex = (i < 12 || i > 20) ? 32'h0 : 32'(mdl[i]);
    apb(1'b0, 12'(4 * i), 16'h0, 4'h0, rd, er);
    chk_val("read data", ex, rd);
    chk_val("read error", {31'h0, i < 12 || i > 20}, {31'h0, er});
  endtask : rdchk
  task automatic delay_run(int c, int n);
    int seen;
    seen = 0;
    sample_req <= 1'b1;
    @(posedge pclk);
    sample_req <= 1'b0;
    for (int t = 0; t < n; t++) begin
      @(posedge pclk);
      mod_tick <= 1'b1;
      #1 seen += (chan_sample[c] === 1'b1);
      @(posedge pclk);
      mod_tick <= 1'b0;
      #1 seen += (chan_sample[c] === 1'b1);
    end
    chk_val("early strobe", 32'h0, seen);
    repeat (4) begin
      @(posedge pclk);
      #1 seen += (chan_sample[c] === 1'b1);
    end
    chk_val("strobe count", 32'h1, seen);
    @(posedge pclk);
  endtask : delay_run
  task automatic trim_run(int c, logic [23:0] d);
    logic signed [23:0] os, rs;
    longint g, y;
    logic [31:0] ey;
    os = c == 1 ? {mdl[15], mdl[16][15:8]} : c == 2 ? {mdl[20], 8'h00} : 24'h0;
    g = c == 1 ? {mdl[17], mdl[18][15:8]} : c == 2 ? 24'h800000 :
        {mdl[12], mdl[13][15:8]};
    rs = d;
    y = ((longint'(rs) - longint'(os)) * g) >>> 23;
    if (y > 8388607) y = 8388607;
    if (y < -8388608) y = -8388608;
    ey = 32'(y[23:0]);
    raw[c].valid <= 1'b1;
    raw[c].data <= d;
    @(posedge pclk);
    raw[c].valid <= 1'b0;
    #1 chk_val("trim valid", 32'h1, {31'h0, trim[c].valid});
    chk_val("trim data", ey, 32'(trim[c].data));
    @(posedge pclk);
  endtask : trim_run
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    for (int i = 12; i <= 20; i++) begin
      mdl[i] = (i == 12 || i == 17) ? 16'h8000 : 16'h0000;
    end
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 11; i <= 21; i++) rdchk(i);
    chk_val("config outputs", 32'h0, {5'h0, c1, c2, tc});
    $display("test reset values done");
    repeat (40) begin
      r = xs();
      k = 11 + r[31:20] % 11;
      wr(k, r[15:0], r[19:16]);
      rdchk(k);
    end
    for (int i = 12; i <= 20; i++) rdchk(i);
    // misaligned and out-of-range addresses of a mapped index
    apb(1'b1, 12'h03a, 16'hffff, 4'h3, r, e);
    chk_val("misaligned error", 32'h1, 32'(e));
    apb(1'b1, 12'h138, 16'hffff, 4'h3, r, e);
    chk_val("high address error", 32'h1, 32'(e));
    apb(1'b0, 12'h03a, 16'h0, 4'h0, r, e);
    chk_val("misaligned read", 32'h0, r);
    rdchk(14);
    $display("test random access done");
    for (int m = 0; m < 8; m++) begin
      r = xs();
      wr(14, {r[15:6], 4'h0, m[1:0]}, 4'h3);
      wr(19, {r[15:6], m[2], m[1], 1'b0, m[0], m[1:0]}, 4'h3);
      chk_val("chan1 select", 32'(m[1:0]), 32'(c1.input_select));
      chk_val("chan2 select", 32'(m[1:0]), 32'(c2.input_select));
      chk_val("temp controls", 32'(m[2:0]), 32'(tc));
      chk_val("chan1 delay", 32'(r[15:6]), 32'(c1.sample_delay));
      chk_val("chan2 delay", 32'(r[15:6]), 32'(c2.sample_delay));
    end
    $display("test field outputs done");
    for (int c = 0; c < 2; c++)
      for (int j = 0; j < 3; j++) begin
        int ph;
        ph = (j == 2) ? 2 : (j == 1) ? -509 : -512;
        // both timers share sample_req, so both get the same phase
        wr(14, {10'(ph), 6'h00}, 4'h3);
        wr(19, {10'(ph), 6'h00}, 4'h3);
        delay_run(c, ph + 512);
      end
    $display("test sample delay done");
    for (int t = 0; t < 18; t++) begin
      r = xs();
      wr(12 + t % 9, r[15:0], 4'h3);
      r = xs();
      trim_run(t % 3, r[23:0]);
    end
    $display("test trim done");
    complete_run();
  end
endmodule : acr_regs_test
